//--- common/lcc_pkg.sv
// Constants for the configurable logic cell control stage.
// Assumes a 32-bit classic Wishbone slave with registers in aligned words.
package lcc_pkg;

  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_POLARITY  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_INPUT_SEL = 8'h0C;
  localparam logic [7:0] OFS_GATE_SEL  = 8'h10;

  localparam int BIT_CELL_ENABLE   = 7;
  localparam int BIT_PIN_DRIVE     = 6;
  localparam int BIT_READBACK      = 5;
  localparam int BIT_RISE_IRQ_EN   = 4;
  localparam int BIT_FALL_IRQ_EN   = 3;
  localparam int BIT_FINAL_INVERT  = 7;
  localparam int BIT_IRQ_FLAG      = 0;

  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  CONTROL_WMASK   = 8'hDF;
  localparam logic [7:0]  POLARITY_MASK   = 8'h8F;
  localparam logic [15:0] INPUT_SEL_MASK  = 16'h7777;

  typedef enum logic [2:0] {
    LCC_AND_OR   = 3'b000,
    LCC_OR_XOR   = 3'b001,
    LCC_AND4     = 3'b010,
    LCC_SR_LATCH = 3'b011,
    LCC_DFF_SR   = 3'b100,
    LCC_DFF2_R   = 3'b101,
    LCC_JK_R     = 3'b110,
    LCC_LATCH_SR = 3'b111
  } lcc_mode_t;

endpackage

//--- hw/lcc_top.sv
// Configurable logic cell: data select, gating, function, output polarity, edge flag.
// Assumes a classic Wishbone master and sources synchronous to sys_clk_in.
`timescale 1ns/100ps
module lcc_top #(
  parameter int SRC_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // candidate source signals
  input  wire logic [SRC_W-1:0]  source_in,
  // cell pin and flag
  output logic                   cell_pin_out,
  output logic                   cell_pin_oe_n_out,
  output logic                   cell_irq_flag_out
);

  function automatic logic src_pick(input logic [SRC_W-1:0] src, input logic [2:0] code);
    src_pick = src[code];
  endfunction

  // bit 2k inverted, bit 2k+1 true of data input k; empty gate gives zero
  function automatic logic gate_and(input logic [7:0] en, input logic [3:0] d);
    logic [7:0] terms;
    terms = {~d[3], d[3], ~d[2], d[2], ~d[1], d[1], ~d[0], d[0]};
    terms = {terms[6], terms[7], terms[4], terms[5], terms[2], terms[3], terms[0], terms[1]};
    gate_and = (|en) & (&(~en | terms));
  endfunction

  logic [7:0]  ctrl_reg;
  logic [7:0]  pol_reg;
  logic [15:0] in_sel_reg;
  logic [31:0] gate_sel_reg;
  logic        flag_reg;
  logic        flag_next;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        state_reg;
  logic        state_next;
  logic        g1_prev_reg;
  logic        out_prev_reg;
  logic        pin_reg;

  // bus decode
  wire         req       = wb_cyc_in & wb_stb_in;
  wire         wr_commit = req & wb_we_in & ack_reg;
  wire         hit_ctrl  = (wb_adr_in == lcc_pkg::OFS_CONTROL);
  wire         hit_pol   = (wb_adr_in == lcc_pkg::OFS_POLARITY);
  wire         hit_stat  = (wb_adr_in == lcc_pkg::OFS_STATUS);
  wire         hit_isel  = (wb_adr_in == lcc_pkg::OFS_INPUT_SEL);
  wire         hit_gsel  = (wb_adr_in == lcc_pkg::OFS_GATE_SEL);
  wire         wr_lo     = wr_commit & wb_sel_in[0];
  wire         flag_clr  = wr_lo & hit_stat & wb_dat_in[lcc_pkg::BIT_IRQ_FLAG];

  // data selection and gating
  wire [3:0]   data_sel;
  wire [3:0]   gate_raw;
  wire [3:0]   g;
  genvar k;
  for (k = 0; k < 4; k++) begin : g_stage
    assign data_sel[k] = src_pick(source_in, in_sel_reg[4*k +: 3]);
    assign gate_raw[k] = gate_and(gate_sel_reg[8*k +: 8], data_sel);
  end
  assign g = gate_raw ^ pol_reg[3:0];

  // logic function
  wire [2:0]   mode         = ctrl_reg[2:0];
  wire         mode_is_comb = (mode == lcc_pkg::LCC_AND_OR) | (mode == lcc_pkg::LCC_OR_XOR)
                            | (mode == lcc_pkg::LCC_AND4);
  wire         g1_edge      = g[0] & ~g1_prev_reg;
  wire         cell_en      = ctrl_reg[lcc_pkg::BIT_CELL_ENABLE];
  logic        comb_result;

  always_comb begin
    case (mode)
      lcc_pkg::LCC_AND_OR: comb_result = (g[0] & g[1]) | (g[2] & g[3]);
      lcc_pkg::LCC_OR_XOR: comb_result = (g[0] | g[1]) ^ (g[2] | g[3]);
      default:             comb_result = &g;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (mode)
      lcc_pkg::LCC_SR_LATCH: begin
        if (g[2] | g[3]) state_next = 1'b0;
        else if (g[0] | g[1]) state_next = 1'b1;
      end
      lcc_pkg::LCC_DFF_SR: begin
        if (g[2]) state_next = 1'b0;
        else if (g[3]) state_next = 1'b1;
        else if (g1_edge) state_next = g[1];
      end
      lcc_pkg::LCC_DFF2_R: begin
        if (g[2]) state_next = 1'b0;
        else if (g1_edge) state_next = g[1] & g[3];
      end
      lcc_pkg::LCC_JK_R: begin
        if (g[2]) state_next = 1'b0;
        else if (g1_edge) state_next = (g[1] & ~state_reg) | (~g[3] & state_reg);
      end
      lcc_pkg::LCC_LATCH_SR: begin
        if (g[2]) state_next = 1'b0;
        else if (g[3]) state_next = 1'b1;
        else if (g[0]) state_next = g[1];
      end
      default: state_next = 1'b0;
    endcase
    if (!cell_en) begin
      state_next = 1'b0;
    end
  end

  wire logic_result = mode_is_comb ? comb_result : state_reg;
  wire cell_out     = cell_en & (logic_result ^ pol_reg[lcc_pkg::BIT_FINAL_INVERT]);

  // edge detectors, sampled each clock
  wire rise_evt = cell_out & ~out_prev_reg & ctrl_reg[lcc_pkg::BIT_RISE_IRQ_EN];
  wire fall_evt = ~cell_out & out_prev_reg & ctrl_reg[lcc_pkg::BIT_FALL_IRQ_EN];
  wire edge_evt = rise_evt | fall_evt;

  always_comb begin
    flag_next = flag_reg;
    if (flag_clr) flag_next = 1'b0;
    if (edge_evt) flag_next = 1'b1;
  end

  // read mux
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_reg[7:6], cell_out, ctrl_reg[4:0]} :
    hit_pol  ? {24'h000000, pol_reg & lcc_pkg::POLARITY_MASK} :
    hit_stat ? {31'h00000000, flag_reg} :
    hit_isel ? {16'h0000, in_sel_reg & lcc_pkg::INPUT_SEL_MASK} :
    hit_gsel ? gate_sel_reg : 32'h00000000;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg     <= lcc_pkg::CONTROL_RESET;
      flag_reg     <= 1'b0;
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h00000000;
      state_reg    <= 1'b0;
      g1_prev_reg  <= 1'b0;
      out_prev_reg <= 1'b0;
      pin_reg      <= 1'b0;
    end else begin
      ack_reg      <= req & ~ack_reg;
      if (req & ~ack_reg) rdata_reg <= rd_mux;
      if (wr_lo & hit_ctrl) ctrl_reg <= wb_dat_in[7:0] & lcc_pkg::CONTROL_WMASK;
      flag_reg     <= flag_next;
      state_reg    <= state_next;
      g1_prev_reg  <= g[0];
      out_prev_reg <= cell_out;
      pin_reg      <= cell_out;
    end
  end

  // configuration kept across reset, undefined at power-up
  always_ff @(posedge sys_clk_in) begin
    if (wr_lo & hit_pol) pol_reg <= wb_dat_in[7:0] & lcc_pkg::POLARITY_MASK;
    if (wr_commit & hit_isel & wb_sel_in[0]) in_sel_reg[7:0] <= wb_dat_in[7:0];
    if (wr_commit & hit_isel & wb_sel_in[1]) in_sel_reg[15:8] <= wb_dat_in[15:8];
    for (int b = 0; b < 4; b++) begin
      if (wr_commit & hit_gsel & wb_sel_in[b]) gate_sel_reg[8*b +: 8] <= wb_dat_in[8*b +: 8];
    end
  end

  assign wb_ack_out        = ack_reg;
  assign wb_dat_out        = rdata_reg;
  assign cell_pin_out      = pin_reg;
  assign cell_pin_oe_n_out = ~ctrl_reg[lcc_pkg::BIT_PIN_DRIVE];
  assign cell_irq_flag_out = flag_reg;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_disabled_out_zero: assert property (!cell_en |-> !cell_out)
    else $error("cell output not zero while disabled");
  a_final_invert_comb: assert property (cell_en && mode == lcc_pkg::LCC_AND_OR
    |-> cell_out == (((g[0] & g[1]) | (g[2] & g[3])) ^ pol_reg[7]))
    else $error("final invert wrong in and-or mode");
  a_and4_result: assert property (cell_en && mode == lcc_pkg::LCC_AND4 && !pol_reg[7]
    |-> cell_out == (g == 4'hF))
    else $error("four-input and wrong");
  a_rise_sets_flag: assert property (cell_en && !$past(cell_out) && cell_out
    && ctrl_reg[4] |=> flag_reg)
    else $error("rising edge did not set flag");
  a_fall_sets_flag: assert property ($past(cell_out) && !cell_out && ctrl_reg[3]
    |=> flag_reg)
    else $error("falling edge did not set flag");
  a_set_beats_clear: assert property (flag_clr && edge_evt |=> flag_reg)
    else $error("edge lost during flag clear");
  a_flag_quiet_hold: assert property (!flag_reg && !edge_evt |=> !flag_reg)
    else $error("flag set without enabled edge");
  a_readback_bit: assert property (req && !wb_we_in && hit_ctrl && !ack_reg
    |=> wb_ack_out && wb_dat_out[5] == $past(cell_out))
    else $error("readback bit mismatch");
  a_pol_zero_bits: assert property (req && !wb_we_in && hit_pol && !ack_reg
    |=> wb_dat_out[6:4] == 3'b000)
    else $error("unimplemented polarity bits not zero");
  a_pin_drive_on: assert property (wr_lo && hit_ctrl && wb_dat_in[6]
    |=> !cell_pin_oe_n_out ##1 cell_pin_out == $past(cell_out))
    else $error("pin drive did not follow control");

  // combinational functions and sequential output
  a_or_xor_result: assert property (
    cell_en && mode == lcc_pkg::LCC_OR_XOR
    |-> cell_out == (((g[0] | g[1]) ^ (g[2] | g[3])) ^ pol_reg[7]))
    else $error("or-xor result wrong");

  a_and4_inverted: assert property (
    cell_en && mode == lcc_pkg::LCC_AND4 && pol_reg[7]
    |-> cell_out == (g != 4'hF))
    else $error("inverted four-input and wrong");

  a_seq_output: assert property (
    cell_en && (mode[2] || mode == lcc_pkg::LCC_SR_LATCH)
    |-> cell_out == (state_reg ^ pol_reg[7]))
    else $error("sequential mode output not from state");

  // data selection and gating
  a_gate_empty_zero: assert property (
    gate_sel_reg[7:0] == 8'h00 && !pol_reg[0]
    |-> !g[0])
    else $error("empty gate not zero");

  a_gate_empty_one: assert property (
    gate_sel_reg[7:0] == 8'h00 && pol_reg[0]
    |-> g[0])
    else $error("inverted empty gate not one");

  a_gate_true_input: assert property (
    gate_sel_reg[7:0] == 8'h02 && !pol_reg[0]
    |-> g[0] == source_in[in_sel_reg[2:0]])
    else $error("gate one does not follow selected source");

  a_gate_inv_input: assert property (
    gate_sel_reg[7:0] == 8'h01 && !pol_reg[0]
    |-> g[0] == !source_in[in_sel_reg[2:0]])
    else $error("gate one does not follow inverted source");

  // sequential modes
  a_sr_set: assert property (
    cell_en && mode == lcc_pkg::LCC_SR_LATCH && !(g[2] | g[3]) && (g[0] | g[1])
    |=> state_reg)
    else $error("s-r latch did not set");

  a_sr_reset: assert property (
    cell_en && mode == lcc_pkg::LCC_SR_LATCH && (g[2] | g[3])
    |=> !state_reg)
    else $error("s-r latch did not reset");

  a_dff_clock: assert property (
    cell_en && mode == lcc_pkg::LCC_DFF_SR && !g[2] && !g[3] && g1_edge
    |=> state_reg == $past(g[1]))
    else $error("d flop did not capture");

  a_dff_set: assert property (
    cell_en && mode == lcc_pkg::LCC_DFF_SR && !g[2] && g[3]
    |=> state_reg)
    else $error("d flop did not set");

  a_dff2_clock: assert property (
    cell_en && mode == lcc_pkg::LCC_DFF2_R && !g[2] && g1_edge
    |=> state_reg == $past(g[1] & g[3]))
    else $error("two-input d flop did not capture");

  a_jk_toggle: assert property (
    cell_en && mode == lcc_pkg::LCC_JK_R && !g[2] && g1_edge && g[1] && g[3]
    |=> state_reg != $past(state_reg))
    else $error("j-k flop did not toggle");

  a_latch_follow: assert property (
    cell_en && mode == lcc_pkg::LCC_LATCH_SR && !g[2] && !g[3] && g[0]
    |=> state_reg == $past(g[1]))
    else $error("transparent latch did not follow");

  a_seq_reset_input: assert property (
    cell_en && mode[2] && g[2]
    |=> !state_reg)
    else $error("reset input ignored");

  a_seq_hold_idle: assert property (
    cell_en && (mode == lcc_pkg::LCC_DFF2_R || mode == lcc_pkg::LCC_JK_R) && !g[2] && !g1_edge
    |=> $stable(state_reg))
    else $error("flop changed without clock");

  a_disabled_state_clear: assert property (
    !cell_en
    |=> !state_reg)
    else $error("state kept while disabled");

  // flag and output polarity
  a_invert_changes_out: assert property (
    cell_en && $stable(ctrl_reg) && $stable(g) && $stable(state_reg) && $changed(pol_reg[7])
    |-> $changed(cell_out))
    else $error("final invert change gave no output edge");

  a_flag_clear_works: assert property (
    flag_clr && !edge_evt
    |=> !flag_reg)
    else $error("flag not cleared");

  a_flag_sticky: assert property (
    flag_reg && !flag_clr
    |=> flag_reg)
    else $error("flag dropped without clear");

  // register bus
  a_ctrl_write_mask: assert property (
    wr_lo && hit_ctrl
    |=> !ctrl_reg[5] && ctrl_reg[7:6] == $past(wb_dat_in[7:6]))
    else $error("control write wrong");

  a_pol_write_mask: assert property (
    wr_lo && hit_pol
    |=> pol_reg[6:4] == 3'b000)
    else $error("unimplemented polarity bits stored");

  a_ack_one_cycle: assert property (
    wb_ack_out
    |=> !wb_ack_out)
    else $error("ack longer than one cycle");

  a_ack_follows_req: assert property (
    req && !ack_reg
    |=> wb_ack_out)
    else $error("no ack after request");

  a_unmapped_read_zero: assert property (
    req && !wb_we_in && !ack_reg && !(hit_ctrl | hit_pol | hit_stat | hit_isel | hit_gsel)
    |=> wb_dat_out == 32'h00000000)
    else $error("unmapped read not zero");

  a_status_read: assert property (
    req && !wb_we_in && hit_stat && !ack_reg
    |=> wb_dat_out == {31'h00000000, $past(flag_reg)})
    else $error("status read wrong");

  // pin and reset
  a_pin_drive_off: assert property (
    !ctrl_reg[lcc_pkg::BIT_PIN_DRIVE]
    |-> cell_pin_oe_n_out)
    else $error("pin driven while drive disabled");

  a_pin_follows: assert property (
    1'b1
    |-> cell_pin_out == $past(cell_out))
    else $error("pin does not follow cell output");

  a_reset_clears_ctrl: assert property (
    disable iff (1'b0) !rst_n_in
    |-> ctrl_reg == 8'h00)
    else $error("control not cleared by reset");

  a_reset_clears_outputs: assert property (
    disable iff (1'b0) !rst_n_in
    |-> !wb_ack_out && !flag_reg && !cell_pin_out && cell_pin_oe_n_out)
    else $error("outputs not cleared by reset");

  c_rise_irq:    cover property (rise_evt ##1 flag_reg);
  c_flag_clear:  cover property (flag_reg ##1 flag_clr ##1 !flag_reg);
  c_jk_toggle:   cover property (cell_en && mode == lcc_pkg::LCC_JK_R && g1_edge ##1 cell_out);
  c_invert_edge: cover property (cell_en && $changed(pol_reg[7]) && edge_evt);
  c_fall_irq:    cover property (fall_evt ##1 flag_reg);

endmodule // lcc_top

//--- tb/tb_lcc_top.sv
// Self-checking bench for the logic cell control stage.
// Assumes lcc_top with a classic Wishbone slave answering one cycle after the request.
`timescale 1ns/100ps
module tb_configurable_logic_cell_control;
  logic        sys_clk_in;
  logic        rst_n_in;
  logic        wb_cyc_in;
  logic        wb_stb_in;
  logic        wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic [7:0]  source_in;
  logic        cell_pin_out;
  logic        cell_pin_oe_n_out;
  logic        cell_irq_flag_out;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [31:0] rdat;

  lcc_top #(.SRC_W(8)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .source_in(source_in),
    .cell_pin_out(cell_pin_out), .cell_pin_oe_n_out(cell_pin_oe_n_out),
    .cell_irq_flag_out(cell_irq_flag_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    rdat = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(nm, rdat, exp);
  endtask

  task automatic drive(input logic [7:0] s, input int n);
    @(posedge sys_clk_in);
    source_in <= s;
    repeat (n) @(posedge sys_clk_in);
  endtask

  // gate n follows true data n, data n follows source n
  function automatic logic comb(input logic [2:0] m, input logic [3:0] s, input logic [7:0] p);
    logic [3:0] g;
    logic       r;
    g = s ^ p[3:0];
    case (m)
      3'h0: r = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
      default: r = &g;
    endcase
    return r ^ p[7];
  endfunction

  task automatic t_reset();
    rd_chk("control", lcc_pkg::OFS_CONTROL, 32'h0);
    check("oe_n", {31'h0, cell_pin_oe_n_out}, 32'h1);
    check("flag", {31'h0, cell_irq_flag_out}, 32'h0);
    wb(1'b1, 8'h20, 32'hFF);
    rd_chk("unmapped", 8'h20, 32'h0);
    wb(1'b1, lcc_pkg::OFS_POLARITY, 32'hFF);
    rd_chk("polarity", lcc_pkg::OFS_POLARITY, 32'h8F);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'hDF);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd_chk("control after reset", lcc_pkg::OFS_CONTROL, 32'h0);
    rd_chk("polarity kept", lcc_pkg::OFS_POLARITY, 32'h8F);
    $display("test reset done");
  endtask

  task automatic t_comb();
    logic [7:0] pols [3] = '{8'h00, 8'h05, 8'h8A};
    logic       e;
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, lcc_pkg::OFS_POLARITY, {24'h0, pols[p]});
      for (int m = 0; m < 3; m++) begin
        // bit 5 written high must not stick
        wb(1'b1, lcc_pkg::OFS_CONTROL, {24'h0, 5'h14, 3'(m)});
        for (int s = 0; s < 16; s++) begin
          drive({4'h0, 4'(s)}, 3);
          e = comb(3'(m), 4'(s), pols[p]);
          check("pin", {31'h0, cell_pin_out}, {31'h0, e});
          rd_chk("readback", lcc_pkg::OFS_CONTROL, {24'h0, 2'h2, e, 2'h0, 3'(m)});
        end
      end
    end
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h40);
    drive(8'h00, 3);
    check("disabled pin", {31'h0, cell_pin_out}, 32'h0);
    check("oe_n on", {31'h0, cell_pin_oe_n_out}, 32'h0);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h00);
    @(posedge sys_clk_in);
    check("oe_n off", {31'h0, cell_pin_oe_n_out}, 32'h1);
    $display("test comb done");
  endtask

  task automatic t_irq();
    wb(1'b1, lcc_pkg::OFS_POLARITY, 32'h0);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h92);
    wb(1'b1, lcc_pkg::OFS_STATUS, 32'h1);
    drive(8'h0F, 4);
    check("rise flag", {31'h0, cell_irq_flag_out}, 32'h1);
    wb(1'b1, lcc_pkg::OFS_STATUS, 32'h1);
    rd_chk("cleared", lcc_pkg::OFS_STATUS, 32'h0);
    drive(8'h00, 4);
    check("fall masked", {31'h0, cell_irq_flag_out}, 32'h0);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h8A);
    drive(8'h0F, 4);
    check("rise masked", {31'h0, cell_irq_flag_out}, 32'h0);
    drive(8'h00, 4);
    check("fall flag", {31'h0, cell_irq_flag_out}, 32'h1);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h92);
    wb(1'b1, lcc_pkg::OFS_STATUS, 32'h1);
    wb(1'b1, lcc_pkg::OFS_POLARITY, 32'h80);
    repeat (3) @(posedge sys_clk_in);
    check("invert flag", {31'h0, cell_irq_flag_out}, 32'h1);
    wb(1'b1, lcc_pkg::OFS_POLARITY, 32'h0);
    $display("test irq done");
  endtask

  // six steps: source nibble and expected pin, first step in the top bits
  task automatic t_seq(input logic [2:0] m, input logic [23:0] s, input logic [5:0] e);
    wb(1'b1, lcc_pkg::OFS_CONTROL, 32'h0);
    drive(8'h00, 2);
    wb(1'b1, lcc_pkg::OFS_CONTROL, {24'h0, 5'h10, m});
    for (int i = 0; i < 6; i++) begin
      drive({4'h0, s[23-4*i -: 4]}, 4);
      check("seq pin", {31'h0, cell_pin_out}, {31'h0, e[5-i]});
    end
    $display("test sequential mode %0d done", m);
  endtask

  initial begin
    rst_n_in = 1'b0;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'hF;
    wb_dat_in = 32'h0;
    source_in = 8'h00;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wb(1'b1, lcc_pkg::OFS_INPUT_SEL, 32'h3210);
    wb(1'b1, lcc_pkg::OFS_GATE_SEL, 32'h80200802);
    t_reset();
    t_comb();
    t_irq();
    t_seq(3'h3, 24'h104010, 6'h33);
    t_seq(3'h4, 24'h230184, 6'h1A);
    t_seq(3'h5, 24'hAB232B, 6'h19);
    t_seq(3'h6, 24'hABAB23, 6'h19);
    t_seq(3'h7, 24'h312326, 6'h26);
    tally_and_finish();
  end
endmodule // tb_configurable_logic_cell_control
